// ---- design/dff_top.sv ----
// Bidirectional queue pair with almost flags, side-B bus sizing and an AHB-Lite register slave.
// Notes on behaviour
// - Side A has a 36-bit two-way data port.
// - Side B 36-bit port, width narrowed by sizing.
// - Side A almost-empty low at low fill.
// - Side B almost-empty low at low fill.
// - Side A almost-full low when little room.
// - Side B almost-full low when little room.
// - Endian pin high at reset: big-endian.
// - Endian pin low at reset: little-endian.
// - After reset the pin selects timing mode.
// - Narrow enable low gives long word width.
// - Side A transfers timed by hclk.
// - Side A flags change only on clock edges.
// - A-to-B is first queue, B-to-A second.
// - Select low to transfer, else outputs off.
`default_nettype none

module dff_queue #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 32,
	parameter int CW = 6
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [CW-1:0] count
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [CW-1:0] count_r;
	logic push;
	logic pop;

	assign in_ready = count_r != CW'(DEPTH);
	assign out_valid = count_r != '0;
	assign out_data = mem_r[rd_ptr_r];
	assign count = count_r;
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule

module dff_top
	import dff_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire dff_port_ctl_type side_a_ctl,
	input wire logic [DATA_W-1:0] side_a_data_bus_in,
	output logic [DATA_W-1:0] side_a_data_bus_out,
	output logic side_a_data_bus_oe_n,
	input wire dff_port_ctl_type side_b_ctl,
	input wire logic [DATA_W-1:0] side_b_data_bus_in,
	output logic [DATA_W-1:0] side_b_data_bus_out,
	output logic side_b_data_bus_oe_n,
	input wire logic endian_timing_select,
	input wire logic narrow_bus_enable,
	input wire logic size_select,
	output logic side_a_almost_empty_n,
	output logic side_a_almost_full_n,
	output logic side_b_almost_empty_n,
	output logic side_b_almost_full_n
);
	localparam int SYNC_W = 2 * DATA_W + 9;

	logic [SYNC_W-1:0] sync1_r;
	logic [SYNC_W-1:0] sync2_r;
	dff_port_ctl_type a_ctl_s;
	dff_port_ctl_type b_ctl_s;
	logic [DATA_W-1:0] a_din_s;
	logic [DATA_W-1:0] b_din_s;
	logic endian_s;
	logic narrow_s;
	logic size_s;

	logic [1:0] cfg_cnt_r;
	logic big_endian_r;
	logic fall_through_mode;
	logic captured;

	logic [CNT_W-1:0] a_to_b_almost_empty_offset_r;
	logic [CNT_W-1:0] b_to_a_almost_empty_offset_r;
	logic [CNT_W-1:0] a_to_b_almost_full_offset_r;
	logic [CNT_W-1:0] b_to_a_almost_full_offset_r;

	logic ab_in_ready;
	logic ab_out_valid;
	logic ab_out_ready;
	logic [DATA_W-1:0] ab_out_data;
	logic [CNT_W-1:0] ab_count;
	logic ba_in_valid;
	logic ba_in_ready;
	logic ba_out_valid;
	logic ba_out_ready;
	logic [DATA_W-1:0] ba_in_data;
	logic [DATA_W-1:0] ba_out_data;
	logic [CNT_W-1:0] ba_count;

	logic a_xfer;
	logic a_read;
	logic b_xfer;
	logic b_read;
	logic b_write;
	logic [2:0] b_lanes;
	logic [1:0] b_rd_idx_r;
	logic [1:0] b_wr_idx_r;
	logic b_rd_last;
	logic b_wr_last;
	logic [DATA_W-1:0] b_asm_r;
	logic [DATA_W-1:0] a_out_r;
	logic a_oe_n_r;
	logic [DATA_W-1:0] b_out_r;
	logic b_oe_n_r;
	logic ae_a_r;
	logic af_a_r;
	logic ae_b_r;
	logic af_b_r;

	logic wr_pend_r;
	logic [ADDR_W-1:0] wr_addr_r;
	logic [31:0] hrdata_r;
	logic hreadyout_r;
	logic addr_phase;

	function automatic logic [1:0] lane_of(input logic [1:0] idx, input logic [2:0] lanes, input logic big);
		lane_of = big ? 2'(lanes - 3'h1 - {1'b0, idx}) : idx;
	endfunction

	function automatic logic [DATA_W-1:0] piece_get(input logic [DATA_W-1:0] w, input logic [1:0] lane,
			input logic [2:0] lanes);
		piece_get = w;
		if (lanes == LANES_BYTE) begin
			piece_get = {{(DATA_W - BYTE_W){1'b0}}, w[int'(lane) * BYTE_W +: BYTE_W]};
		end else if (lanes == LANES_WORD) begin
			piece_get = {{(DATA_W - WORD_W){1'b0}}, w[int'(lane[0]) * WORD_W +: WORD_W]};
		end
	endfunction

	function automatic logic [DATA_W-1:0] piece_put(input logic [DATA_W-1:0] w, input logic [DATA_W-1:0] p,
			input logic [1:0] lane, input logic [2:0] lanes);
		piece_put = p;
		if (lanes == LANES_BYTE) begin
			piece_put = w;
			piece_put[int'(lane) * BYTE_W +: BYTE_W] = p[BYTE_W-1:0];
		end else if (lanes == LANES_WORD) begin
			piece_put = w;
			piece_put[int'(lane[0]) * WORD_W +: WORD_W] = p[WORD_W-1:0];
		end
	endfunction

	// Every pin input is resynchronised, so a transfer acts on the third edge after the pins present it.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= {side_a_ctl, side_a_data_bus_in, side_b_ctl, side_b_data_bus_in,
				endian_timing_select, narrow_bus_enable, size_select};
			sync2_r <= sync1_r;
		end
	end

	assign {a_ctl_s, a_din_s, b_ctl_s, b_din_s, endian_s, narrow_s, size_s} = sync2_r;

	// The endian level is caught once the synchroniser holds post-reset values, then frozen.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_cnt_r <= '0;
			big_endian_r <= 1'b0;
		end else if (!captured) begin
			cfg_cnt_r <= cfg_cnt_r + 1'b1;
			big_endian_r <= endian_s;
		end
	end

	assign captured = cfg_cnt_r == CAPTURE_CYCLES;
	assign fall_through_mode = captured & ~endian_s;
	assign b_lanes = !narrow_s ? LANES_LONG : (size_s ? LANES_BYTE : LANES_WORD);

	dff_queue #(
		.WIDTH(DATA_W),
		.DEPTH(DEPTH),
		.CW(CNT_W)
	) a_to_b_queue (
		.clk(hclk),
		.rst_n(hresetn),
		.in_valid(a_xfer & a_ctl_s.write),
		.in_ready(ab_in_ready),
		.in_data(a_din_s),
		.out_valid(ab_out_valid),
		.out_ready(ab_out_ready),
		.out_data(ab_out_data),
		.count(ab_count)
	);

	dff_queue #(
		.WIDTH(DATA_W),
		.DEPTH(DEPTH),
		.CW(CNT_W)
	) b_to_a_queue (
		.clk(hclk),
		.rst_n(hresetn),
		.in_valid(ba_in_valid),
		.in_ready(ba_in_ready),
		.in_data(ba_in_data),
		.out_valid(ba_out_valid),
		.out_ready(ba_out_ready),
		.out_data(ba_out_data),
		.count(ba_count)
	);

	// Side A: a write into a full queue and a read of an empty one are both dropped.
	assign a_xfer = captured & ~a_ctl_s.select_n & a_ctl_s.enable;
	assign a_read = a_xfer & ~a_ctl_s.write;
	assign ba_out_ready = a_read;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_out_r <= '0;
			a_oe_n_r <= 1'b1;
		end else begin
			// The synchroniser resets to a selected read, so the drivers stay off until capture.
			a_oe_n_r <= ~captured | a_ctl_s.select_n | a_ctl_s.write;
			if (fall_through_mode ? ba_out_valid : (a_read & ba_out_valid)) begin
				a_out_r <= ba_out_data;
			end
		end
	end

	// Side B moves one lane per transfer; the queue word is popped or pushed on the last lane.
	assign b_xfer = captured & ~b_ctl_s.select_n & b_ctl_s.enable;
	assign b_read = b_xfer & ~b_ctl_s.write & ab_out_valid;
	assign b_write = b_xfer & b_ctl_s.write & ba_in_ready;
	assign b_rd_last = {1'b0, b_rd_idx_r} == b_lanes - 3'h1;
	assign b_wr_last = {1'b0, b_wr_idx_r} == b_lanes - 3'h1;
	assign ab_out_ready = b_read & b_rd_last;
	assign ba_in_valid = b_write & b_wr_last;
	assign ba_in_data = piece_put(b_asm_r, b_din_s, lane_of(b_wr_idx_r, b_lanes, big_endian_r), b_lanes);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			b_rd_idx_r <= '0;
			b_out_r <= '0;
			b_oe_n_r <= 1'b1;
		end else begin
			b_oe_n_r <= ~captured | b_ctl_s.select_n | b_ctl_s.write;
			if (b_read) begin
				b_rd_idx_r <= b_rd_last ? 2'h0 : b_rd_idx_r + 1'b1;
			end
			if (fall_through_mode ? ab_out_valid : b_read) begin
				b_out_r <= piece_get(ab_out_data, lane_of(b_rd_idx_r, b_lanes, big_endian_r), b_lanes);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			b_wr_idx_r <= '0;
			b_asm_r <= '0;
		end else if (b_write) begin
			b_wr_idx_r <= b_wr_last ? 2'h0 : b_wr_idx_r + 1'b1;
			b_asm_r <= b_wr_last ? '0 : ba_in_data;
		end
	end

	// Flags are compared against the live counts and registered, so they trail the queue by one edge.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ae_a_r <= 1'b0;
			af_a_r <= 1'b1;
			ae_b_r <= 1'b0;
			af_b_r <= 1'b1;
		end else begin
			ae_a_r <= ~(ba_count <= b_to_a_almost_empty_offset_r);
			ae_b_r <= ~(ab_count <= a_to_b_almost_empty_offset_r);
			af_a_r <= ~((CNT_W'(DEPTH) - ab_count) <= a_to_b_almost_full_offset_r);
			af_b_r <= ~((CNT_W'(DEPTH) - ba_count) <= b_to_a_almost_full_offset_r);
		end
	end

	// AHB-Lite slave with no wait states; reads are sampled at the address phase.
	assign addr_phase = hsel & hready & ((htrans & HTRANS_NONSEQ_BIT) != 2'h0);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= '0;
			hrdata_r <= '0;
			hreadyout_r <= 1'b1;
		end else begin
			hreadyout_r <= 1'b1;
			wr_pend_r <= addr_phase & hwrite;
			wr_addr_r <= haddr[ADDR_W-1:0];
			if (addr_phase && !hwrite) begin
				hrdata_r <= '0;
				unique case (haddr[ADDR_W-1:0])
					ADDR_AB_AE_OFS: hrdata_r[CNT_W-1:0] <= a_to_b_almost_empty_offset_r;
					ADDR_BA_AE_OFS: hrdata_r[CNT_W-1:0] <= b_to_a_almost_empty_offset_r;
					ADDR_AB_AF_OFS: hrdata_r[CNT_W-1:0] <= a_to_b_almost_full_offset_r;
					ADDR_BA_AF_OFS: hrdata_r[CNT_W-1:0] <= b_to_a_almost_full_offset_r;
					ADDR_STATUS: begin
						hrdata_r[ST_AB_COUNT_LSB +: CNT_W] <= ab_count;
						hrdata_r[ST_BA_COUNT_LSB +: CNT_W] <= ba_count;
						hrdata_r[ST_BIG_ENDIAN] <= big_endian_r;
						hrdata_r[ST_FALL_THROUGH] <= fall_through_mode;
						hrdata_r[ST_NARROW] <= narrow_s;
						hrdata_r[ST_BYTE_SIZE] <= size_s;
						hrdata_r[ST_CAPTURED] <= captured;
					end
					default: hrdata_r <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_to_b_almost_empty_offset_r <= OFS_RESET;
			b_to_a_almost_empty_offset_r <= OFS_RESET;
			a_to_b_almost_full_offset_r <= OFS_RESET;
			b_to_a_almost_full_offset_r <= OFS_RESET;
		end else if (wr_pend_r) begin
			unique case (wr_addr_r)
				ADDR_AB_AE_OFS: a_to_b_almost_empty_offset_r <= hwdata[CNT_W-1:0];
				ADDR_BA_AE_OFS: b_to_a_almost_empty_offset_r <= hwdata[CNT_W-1:0];
				ADDR_AB_AF_OFS: a_to_b_almost_full_offset_r <= hwdata[CNT_W-1:0];
				ADDR_BA_AF_OFS: b_to_a_almost_full_offset_r <= hwdata[CNT_W-1:0];
				default: ;
			endcase
		end
	end

	assign hreadyout = hreadyout_r;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;
	assign side_a_data_bus_out = a_out_r;
	assign side_a_data_bus_oe_n = a_oe_n_r;
	assign side_b_data_bus_out = b_out_r;
	assign side_b_data_bus_oe_n = b_oe_n_r;
	assign side_a_almost_empty_n = ae_a_r;
	assign side_a_almost_full_n = af_a_r;
	assign side_b_almost_empty_n = ae_b_r;
	assign side_b_almost_full_n = af_b_r;
endmodule
`default_nettype wire

// ---- design/dff_pkg.sv ----
// Shared constants and carrier types for the dual flagged FIFO block.
`default_nettype none
package dff_pkg;
	localparam int DATA_W = 36;
	localparam int FIFO_DEPTH = 32;
	localparam int CNT_W = 6;
	localparam int BYTE_W = 9;
	localparam int WORD_W = 18;
	localparam int ADDR_W = 8;
	localparam logic [2:0] LANES_LONG = 3'h1;
	localparam logic [2:0] LANES_WORD = 3'h2;
	localparam logic [2:0] LANES_BYTE = 3'h4;
	localparam logic [7:0] ADDR_AB_AE_OFS = 8'h00;
	localparam logic [7:0] ADDR_BA_AE_OFS = 8'h04;
	localparam logic [7:0] ADDR_AB_AF_OFS = 8'h08;
	localparam logic [7:0] ADDR_BA_AF_OFS = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [CNT_W-1:0] OFS_RESET = 6'h08;
	localparam logic [1:0] CAPTURE_CYCLES = 2'h3;
	localparam int ST_AB_COUNT_LSB = 0;
	localparam int ST_BA_COUNT_LSB = 8;
	localparam int ST_BIG_ENDIAN = 16;
	localparam int ST_FALL_THROUGH = 17;
	localparam int ST_NARROW = 18;
	localparam int ST_BYTE_SIZE = 19;
	localparam int ST_CAPTURED = 20;
	localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;
	typedef struct packed {
		logic enable;
		logic select_n;
		logic write;
	} dff_port_ctl_type;
endpackage
`default_nettype wire

// ---- verification/dff_monitor.sv ----
// Port checker for the dual flagged queue block.
`default_nettype none
module dff_monitor
	import dff_pkg::*;
#(
	parameter int DEPTH = 32
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire dff_port_ctl_type side_a_ctl,
	input wire logic side_a_data_bus_oe_n,
	input wire dff_port_ctl_type side_b_ctl,
	input wire logic side_b_data_bus_oe_n,
	input wire logic side_a_almost_empty_n,
	input wire logic side_a_almost_full_n,
	input wire logic side_b_almost_empty_n,
	input wire logic side_b_almost_full_n
);
	logic [3:0] a_age_r;
	logic [3:0] b_age_r;
	logic bus_wr;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	assign bus_wr = hsel && htrans[1] && hwrite;
	// An almost-full flag may only fall, and an almost-empty flag only rise, soon after a push into its queue or a bus write; the ages saturate.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_age_r <= 4'hf;
			b_age_r <= 4'hf;
		end else begin
			a_age_r <= (side_a_ctl == 3'h5 || bus_wr) ? 4'h0 : (a_age_r == 4'hf ? a_age_r : a_age_r + 4'h1);
			b_age_r <= (side_b_ctl == 3'h5 || bus_wr) ? 4'h0 : (b_age_r == 4'hf ? b_age_r : b_age_r + 4'h1);
		end
	end
	okay_resp_a: assert property (hresp == 1'b0)
		else $error("hresp not OKAY");
	zero_wait_a: assert property (hreadyout)
		else $error("hreadyout low");
	a_bus_off_a: assert property ((side_a_ctl.select_n || side_a_ctl.write) [*4] |=> side_a_data_bus_oe_n)
		else $error("side A driven while idle");
	b_bus_off_a: assert property ((side_b_ctl.select_n || side_b_ctl.write) [*4] |=> side_b_data_bus_oe_n)
		else $error("side B driven while idle");
	a_full_cause_a: assert property ($fell(side_a_almost_full_n) |-> a_age_r < 4'h8)
		else $error("side A almost full fell without a push");
	b_empty_cause_a: assert property ($rose(side_b_almost_empty_n) |-> a_age_r < 4'h8)
		else $error("side B almost empty rose without a push");
	b_full_cause_a: assert property ($fell(side_b_almost_full_n) |-> b_age_r < 4'h8)
		else $error("side B almost full fell without a push");
	a_empty_cause_a: assert property ($rose(side_a_almost_empty_n) |-> b_age_r < 4'h8)
		else $error("side A almost empty rose without a push");
	cover property (side_a_ctl == 3'h5);
	cover property (side_b_ctl == 3'h4);
	cover property ($fell(side_a_almost_full_n));
endmodule
bind dff_top dff_monitor #(.DEPTH(DEPTH)) dff_monitor_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp), .side_a_ctl(side_a_ctl),
	.side_a_data_bus_oe_n(side_a_data_bus_oe_n), .side_b_ctl(side_b_ctl), .side_b_data_bus_oe_n(side_b_data_bus_oe_n),
	.side_a_almost_empty_n(side_a_almost_empty_n), .side_a_almost_full_n(side_a_almost_full_n),
	.side_b_almost_empty_n(side_b_almost_empty_n), .side_b_almost_full_n(side_b_almost_full_n));
`default_nettype wire

// ---- verification/dff_b_host.sv ----
// Side-B host model: one read or write per request.
`default_nettype none
module dff_b_host
	import dff_pkg::*;
(
	input wire logic hclk,
	input wire logic req,
	input wire logic wr,
	input wire logic [DATA_W-1:0] wdata,
	output var dff_port_ctl_type ctl,
	output var logic [DATA_W-1:0] bus_in
);
	initial begin
		ctl = 3'h2;
		bus_in = '0;
	end
	// A released bus shows the inverse of its last value, so stale data never passes for new data.
	always @(posedge hclk) begin
		ctl <= req ? {1'b1, 1'b0, wr} : 3'h2;
		bus_in <= (req && wr) ? wdata : ~bus_in;
	end
endmodule
`default_nettype wire

// ---- verification/dff_top_tb.sv ----
// Self-checking bench for the dual flagged queue block.
`default_nettype none
module dff_top_tb
	import dff_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = '0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata, junk;
	logic hreadyout, hresp, a_oe_n, b_oe_n, a_ae_n, a_af_n, b_ae_n, b_af_n;
	logic pin = 1'b1, narrow = 1'b0, size = 1'b0, req = 1'b0, wr = 1'b0;
	dff_port_ctl_type a_ctl = 3'h2;
	dff_port_ctl_type b_ctl;
	logic [DATA_W-1:0] a_in = '0, wdata = '0, a_out, b_in, b_out;
	int err_total = 0, check_count = 0, cyc = 0;
	dff_top #(.DEPTH(FIFO_DEPTH)) dff_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .side_a_ctl(a_ctl), .side_a_data_bus_in(a_in), .side_a_data_bus_out(a_out),
		.side_a_data_bus_oe_n(a_oe_n), .side_b_ctl(b_ctl), .side_b_data_bus_in(b_in), .side_b_data_bus_out(b_out),
		.side_b_data_bus_oe_n(b_oe_n), .endian_timing_select(pin), .narrow_bus_enable(narrow), .size_select(size),
		.side_a_almost_empty_n(a_ae_n), .side_a_almost_full_n(a_af_n), .side_b_almost_empty_n(b_ae_n),
		.side_b_almost_full_n(b_af_n));
	dff_b_host dff_b_host_inst (.hclk(hclk), .req(req), .wr(wr), .wdata(wdata), .ctl(b_ctl), .bus_in(b_in));
	initial begin
		forever #50 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			test_done();
		end
	end
	task automatic test_done();
		if (err_total == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic ahb(input logic wrt, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wrt;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string what);
		ahb(1'b0, a, 32'h0, junk);
		chk(what, {4'h0, exp}, {4'h0, junk & m});
	endtask
	// The pin settles on its timing level once the endian level is caught and then stays put.
	task automatic rst(input logic be, input logic nar, input logic sz, input logic tm);
		hresetn <= 1'b0;
		pin <= be;
		narrow <= nar;
		size <= sz;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (3) @(posedge hclk);
		pin <= tm;
		repeat (3) @(posedge hclk);
		rd_chk(ADDR_STATUS, 32'h1f0000, {11'h0, 1'b1, sz, nar, ~tm, be, 16'h0}, "mode");
	endtask
	task automatic push_a(input int n, input logic [35:0] base);
		for (int i = 0; i < n; i++) begin
			@(posedge hclk);
			a_ctl <= 3'h5;
			a_in <= base + 36'(i);
		end
		@(posedge hclk);
		a_ctl <= 3'h2;
		a_in <= ~a_in;
		repeat (6) @(posedge hclk);
	endtask
	task automatic pop_a();
		@(posedge hclk);
		a_ctl <= 3'h4;
		@(posedge hclk);
		a_ctl <= 3'h2;
		repeat (2) @(posedge hclk);
		@(negedge hclk);
		chk("a_oe_n", 36'h0, {35'h0, a_oe_n});
		repeat (4) @(posedge hclk);
	endtask
	task automatic b_op(input logic w, input logic [35:0] d);
		@(posedge hclk);
		req <= 1'b1;
		wr <= w;
		wdata <= d;
		@(posedge hclk);
		req <= 1'b0;
		repeat (3) @(posedge hclk);
		@(negedge hclk);
		chk("b_oe_n", {35'h0, w}, {35'h0, b_oe_n});
		repeat (3) @(posedge hclk);
	endtask
	task automatic t_reset();
		rd_chk(ADDR_AB_AE_OFS, 32'h3f, 32'h8, "offset");
		rd_chk(8'h14, 32'hffffffff, 32'h0, "hole");
		chk("a_ae", 36'h0, {35'h0, a_ae_n});
		chk("b_ae", 36'h0, {35'h0, b_ae_n});
		chk("a_af", 36'h1, {35'h0, a_af_n});
		chk("b_af", 36'h1, {35'h0, b_af_n});
	endtask
	// The 33rd push must be dropped; the drain then walks both flags across their boundaries.
	task automatic t_fill();
		push_a(33, 36'h800000000);
		rd_chk(ADDR_STATUS, 32'h3f, 32'h20, "fill");
		for (int i = 0; i < 32; i++) begin
			b_op(1'b0, '0);
			chk("b_data", 36'h800000000 + 36'(i), b_out);
			chk("b_ae", 36'((31 - i) > 8), {35'h0, b_ae_n});
			chk("a_af", 36'((i + 1) > 8), {35'h0, a_af_n});
		end
	endtask
	task automatic t_ba();
		ahb(1'b1, ADDR_BA_AE_OFS, 32'h0, junk);
		ahb(1'b1, ADDR_BA_AF_OFS, 32'h1f, junk);
		b_op(1'b1, 36'h123456789);
		chk("a_ae", 36'h1, {35'h0, a_ae_n});
		chk("b_af", 36'h0, {35'h0, b_af_n});
		pop_a();
		chk("a_data", 36'h123456789, a_out);
		chk("a_ae", 36'h0, {35'h0, a_ae_n});
		chk("b_af", 36'h1, {35'h0, b_af_n});
	endtask
	task automatic t_size(input logic be, input logic sz, input int n, input int w);
		logic [35:0] m;
		int s;
		m = (36'h1 << w) - 36'h1;
		rst(be, 1'b1, sz, 1'b1);
		push_a(1, 36'h9abcdef12);
		for (int i = 0; i < n; i++) begin
			s = be ? w * (n - 1 - i) : w * i;
			b_op(1'b0, '0);
			chk("b_piece", (36'h9abcdef12 >> s) & m, b_out);
			b_op(1'b1, (36'h9abcdef12 >> s) & m);
		end
		pop_a();
		chk("a_word", 36'h9abcdef12, a_out);
	endtask
	// Fall-through: a word pushed on side B shows on side A with no read.
	task automatic t_ft();
		rst(1'b0, 1'b0, 1'b0, 1'b0);
		b_op(1'b1, 36'h0fedcba98);
		chk("ft_data", 36'h0fedcba98, a_out);
	endtask
	initial begin
		rst(1'b1, 1'b0, 1'b0, 1'b1);
		t_reset();
		t_fill();
		t_ba();
		t_size(1'b1, 1'b0, 2, 18);
		t_size(1'b0, 1'b1, 4, 9);
		t_ft();
		test_done();
	end
endmodule
`default_nettype wire
